// [core/srp_pkg.sv]
// Behaviour
// - host runs serial clock before any access
// - low chip select starts a transfer
// - header is eight serial bits
// - device samples header bits on rising edges
// - first bit: one read, zero write
// - bits two to six: address, lsb first
// - host sends zero bit seven; eight ignored
// - read output enabled at falling edge eight
// - read data five bits lsb first, falling
// - host captures read bit at next rise
// - write data before rising edge nine
// - write data eight bits lsb first, rising
// - output tri-stated unless driving read data
package srp_pkg;
  localparam int HDR_BITS = 8;
  localparam int ADDR_W = 5;
  localparam int RDATA_W = 5;
  localparam int WDATA_W = 8;
  localparam int ADDR_POS = 1;
  localparam int DEPTH = 32;
  localparam logic [4:0] REG_RESET = 5'h00;
  localparam int SCK_HALF = 4;
  localparam logic [4:0] CNT_HDR_DONE = 5'h08;
  localparam logic [4:0] CNT_RD_DONE = 5'h0D;
  localparam logic [4:0] CNT_WR_DONE = 5'h10;
endpackage

// [core/srp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface srp_if;
  logic csN;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdoOeN;
  modport dev (input csN, input sclk, input sdi, output sdo, output sdoOeN);
  modport host (output csN, output sclk, output sdi, input sdo,
    input sdoOeN);
endinterface // srp_if
`default_nettype wire

// [core/srp_device.sv]
`timescale 1ns/1ps
`default_nettype none
module srp_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  srp_if.dev link,
  output logic [4:0] regData [0:31],
  output logic wrPulse,
  output logic [4:0] wrAddr
);
  // frame phase; cs high returns to idle from anywhere
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_HDR = 3'b001,
    PH_WRITE = 3'b011,
    PH_READ = 3'b101,
    PH_DONE = 3'b111
  } srp_phase_t;

  // pin synchronisers
  logic [1:0] csSync_reg;
  logic [1:0] csSync_next;
  logic [2:0] ckSync_reg;
  logic [2:0] ckSync_next;
  logic [1:0] diSync_reg;
  logic [1:0] diSync_next;
  logic csLow;
  logic rise;
  logic fall;
  logic di;

  // frame control
  srp_phase_t ph_reg;
  srp_phase_t ph_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [7:0] hdr_reg;
  logic [7:0] hdr_next;
  logic [4:0] addr;

  // write path
  logic [7:0] wsh_reg;
  logic [7:0] wsh_next;
  logic wr_reg;
  logic wr_next;

  // read path
  logic [4:0] rsh_reg;
  logic [4:0] rsh_next;
  logic sdo_reg;
  logic sdo_next;
  logic oeN_reg;
  logic oeN_next;
  logic [4:0] selData;

  // register store
  logic [4:0] mem_reg [0:31];
  logic [4:0] mem_next [0:31];

  always_comb begin
    csSync_next = {csSync_reg[0], link.csN};
    ckSync_next = {ckSync_reg[1:0], link.sclk};
    diSync_next = {diSync_reg[0], link.sdi};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      csSync_reg <= 2'h3;
      ckSync_reg <= 3'h0;
      diSync_reg <= 2'h0;
    end else begin
      csSync_reg <= csSync_next;
      ckSync_reg <= ckSync_next;
      diSync_reg <= diSync_next;
    end
  end

  // sclk needs at least six sys_clk per period to be seen
  always_comb begin
    csLow = !csSync_reg[1];
    rise = ckSync_reg[1] && !ckSync_reg[2];
    fall = !ckSync_reg[1] && ckSync_reg[2];
    di = diSync_reg[1];
    addr = hdr_reg[5:1];
    selData = mem_reg[addr];
  end

  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    if (!csLow) begin
      ph_next = PH_IDLE;
      cnt_next = 5'h00;
    end else begin
      // saturate so a long frame never wraps into a new header
      if (rise && cnt_reg != 5'h1F) begin
        cnt_next = cnt_reg + 5'h01;
      end
      case (ph_reg)
        PH_IDLE, PH_HDR: begin
          ph_next = PH_HDR;
          if (rise) begin
            hdr_next = {di, hdr_reg[7:1]};
            // bit seven is expected zero, bit eight is ignored
            if (cnt_reg == srp_pkg::CNT_HDR_DONE - 5'h01) begin
              ph_next = hdr_next[0] ? PH_READ : PH_WRITE;
            end
          end
        end
        PH_WRITE: begin
          if (rise && cnt_reg == srp_pkg::CNT_WR_DONE - 5'h01) begin
            ph_next = PH_DONE;
          end
        end
        PH_READ: begin
          if (fall && cnt_reg >= srp_pkg::CNT_RD_DONE) begin
            ph_next = PH_DONE;
          end
        end
        default: begin
          ph_next = ph_reg;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_reg <= PH_IDLE;
      cnt_reg <= 5'h00;
      hdr_reg <= 8'h00;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
    end
  end

  always_comb begin
    wsh_next = wsh_reg;
    wr_next = 1'b0;
    if (csLow && ph_reg == PH_WRITE && rise) begin
      wsh_next = {di, wsh_reg[7:1]};
      if (cnt_reg == srp_pkg::CNT_WR_DONE - 5'h01) begin
        wr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wsh_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else begin
      wsh_reg <= wsh_next;
      wr_reg <= wr_next;
    end
  end

  // one-wire hosts need sdo released outside the data bits
  always_comb begin
    rsh_next = rsh_reg;
    sdo_next = sdo_reg;
    oeN_next = oeN_reg;
    if (!csLow || ph_reg != PH_READ) begin
      oeN_next = 1'b1;
    end else if (fall) begin
      if (cnt_reg == srp_pkg::CNT_HDR_DONE) begin
        sdo_next = selData[0];
        rsh_next = {1'b0, selData[4:1]};
        oeN_next = 1'b0;
      end else if (cnt_reg < srp_pkg::CNT_RD_DONE) begin
        sdo_next = rsh_reg[0];
        rsh_next = {1'b0, rsh_reg[4:1]};
      end else begin
        oeN_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsh_reg <= 5'h00;
      sdo_reg <= 1'b0;
      oeN_reg <= 1'b1;
    end else begin
      rsh_reg <= rsh_next;
      sdo_reg <= sdo_next;
      oeN_reg <= oeN_next;
    end
  end

  always_comb begin
    mem_next = mem_reg;
    if (wr_reg) begin
      // only five bits are kept; write bits five to seven drop
      mem_next[addr] = wsh_reg[4:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        mem_reg[i] <= srp_pkg::REG_RESET;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign link.sdo = sdo_reg;
  assign link.sdoOeN = oeN_reg;
  assign regData = mem_reg;
  assign wrPulse = wr_reg;
  assign wrAddr = addr;
endmodule // srp_device
`default_nettype wire

// [core/srp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module srp_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  srp_if.host link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic [4:0] reqAddr,
  input wire logic [7:0] reqWdata,
  output logic rspValid,
  output logic [4:0] rspData
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_LEAD = 2'b01,
    H_RUN = 2'b11, H_TAIL = 2'b10} srp_hst_t;
  srp_hst_t st_reg, st_next;
  logic [2:0] div_reg, div_next;
  logic [4:0] bit_reg, bit_next;
  logic sck_reg, sck_next, cs_reg, cs_next, di_reg, di_next;
  logic rd_reg, rd_next;
  logic [15:0] frm_reg, frm_next;
  logic [4:0] rdat_reg, rdat_next;
  logic rv_reg, rv_next;
  logic [1:0] doSync_reg, doSync_next;
  logic tick;
  always_comb begin
    doSync_next = {doSync_reg[0], link.sdo};
    tick = (div_reg == 3'(srp_pkg::SCK_HALF - 1));
    div_next = tick ? 3'h0 : div_reg + 3'h1;
    // clock runs free, also outside frames
    sck_next = tick ? !sck_reg : sck_reg;
    st_next = st_reg;
    bit_next = bit_reg;
    cs_next = cs_reg;
    di_next = di_reg;
    rd_next = rd_reg;
    frm_next = frm_reg;
    rdat_next = rdat_reg;
    rv_next = 1'b0;
    reqReady = (st_reg == H_IDLE);
    case (st_reg)
      H_IDLE: begin
        if (reqValid) begin
          // header lsb first: rw, a0..a4, zero, dont care
          frm_next = {reqWdata, 1'b0, 1'b0,
            reqAddr, reqRead};
          rd_next = reqRead;
          st_next = H_LEAD;
        end
      end
      H_LEAD: begin
        if (tick && sck_reg) begin // falling edge coming
          cs_next = 1'b0;
          di_next = frm_reg[0];
          frm_next = {1'b0, frm_reg[15:1]};
          bit_next = 5'h00;
          st_next = H_RUN;
        end
      end
      H_RUN: begin
        // sdo returns through two synchronisers, so each bit is
        // taken two cycles after the rise that should capture it
        if (rd_reg && sck_reg && div_reg == 3'h1
            && bit_reg > srp_pkg::CNT_HDR_DONE) begin
          rdat_next = {doSync_reg[1], rdat_reg[4:1]};
        end
        if (tick && !sck_reg) begin // rising edge
          bit_next = bit_reg + 5'h01;
        end
        if (tick && sck_reg) begin // falling edge
          di_next = frm_reg[0];
          frm_next = {1'b0, frm_reg[15:1]};
          if (bit_reg == (rd_reg ? srp_pkg::CNT_RD_DONE
              : srp_pkg::CNT_WR_DONE)) begin
            st_next = H_TAIL;
          end
        end
      end
      H_TAIL: begin
        cs_next = 1'b1;
        rv_next = rd_reg;
        st_next = H_IDLE;
      end
      default: st_next = H_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= H_IDLE;
      div_reg <= 3'h0;
      bit_reg <= 5'h00;
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
      di_reg <= 1'b0;
      rd_reg <= 1'b0;
      frm_reg <= 16'h0000;
      rdat_reg <= 5'h00;
      rv_reg <= 1'b0;
      doSync_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      sck_reg <= sck_next;
      cs_reg <= cs_next;
      di_reg <= di_next;
      rd_reg <= rd_next;
      frm_reg <= frm_next;
      rdat_reg <= rdat_next;
      rv_reg <= rv_next;
      doSync_reg <= doSync_next;
    end
  end
  assign link.csN = cs_reg;
  assign link.sclk = sck_reg;
  assign link.sdi = di_reg;
  assign rspValid = rv_reg;
  assign rspData = rdat_reg;
endmodule // srp_host
`default_nettype wire

// [verif/srp_link_props.sv]
`timescale 1ns/1ps
`default_nettype none
module srp_link_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdoOeN
);
  logic sclkDly_reg;
  logic rd_reg, rd_next;
  logic [4:0] rises_reg, rises_next;
  wire logic sclkRise = sclk & ~sclkDly_reg;
  wire logic sclkFall = ~sclk & sclkDly_reg;
  always_comb begin
    rises_next = rises_reg;
    rd_next = rd_reg;
    if (csN) begin
      rises_next = 5'h00;
    end else if (sclkRise) begin
      rises_next = rises_reg + 5'h01;
      if (rises_reg == 5'h00) rd_next = sdi;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclkDly_reg <= 1'b0;
      rd_reg <= 1'b0;
      rises_reg <= 5'h00;
    end else begin
      sclkDly_reg <= sclk;
      rd_reg <= rd_next;
      rises_reg <= rises_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence hdrDone;
    !csN && rd_reg && sclkFall && rises_reg == 5'h08;
  endsequence
  sequence frameEnd;
    $rose(csN);
  endsequence
  idle_tristate_a: assert property (csN [*5] |-> sdoOeN)
    else $error("sdo driven outside frame");
  drive_window_a: assert property (
    (!sdoOeN && !csN && rises_reg != 5'h00) |-> rises_reg >= 5'h08 && rd_reg)
    else $error("sdo driven early");
  drive_start_a: assert property (hdrDone |-> ##[1:6] !sdoOeN)
    else $error("sdo not enabled after header");
  sdo_hold_a: assert property (
    (!sdoOeN && sclk && sclkDly_reg) |-> $stable(sdo))
    else $error("sdo moved while clock high");
  sdi_hold_a: assert property (
    (!csN && sclk && sclkDly_reg) |-> $stable(sdi))
    else $error("sdi moved while clock high");
  bit_seven_a: assert property (
    (sclkRise && rises_reg == 5'h06) |-> !sdi)
    else $error("header bit seven not zero");
  write_len_a: assert property (
    (frameEnd and !rd_reg) ##0 1 |-> rises_reg == 5'h10)
    else $error("write frame length");
  read_len_a: assert property (
    (frameEnd and rd_reg) ##0 1 |-> rises_reg >= 5'h0D)
    else $error("read frame short");
  frame_gap_a: assert property (frameEnd |=> csN)
    else $error("no gap between frames");
endmodule // srp_link_props
`default_nettype wire

// [verif/serial_register_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_register_port_test;
  logic sys_clk, sys_rst, reqValid, reqReady, reqRead, rspValid, wrPulse;
  logic [4:0] reqAddr, rspData, wrAddr, q;
  logic [7:0] reqWdata;
  logic [4:0] regData [0:31];
  int miscompares, checked, cycles;
  srp_if link();
  srp_device u_srp_device(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .regData(regData), .wrPulse(wrPulse), .wrAddr(wrAddr));
  srp_host u_srp_host(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid),
    .rspData(rspData));
  srp_link_props u_props(.sys_clk(sys_clk), .sys_rst(sys_rst),
    .csN(link.csN), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
    .sdoOeN(link.sdoOeN));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ceiling well above fifteen frames of about 140 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task xfer(input logic rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    reqValid = 1;
    reqRead = rd;
    reqAddr = a;
    reqWdata = d;
    while (reqReady !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1 reqValid = 0;
    n = 0;
    while ((rd ? rspValid : wrPulse) !== 1'b1 && n < 400) begin
      @(posedge sys_clk) #1 n++;
    end
    chk("finish", 8'(n < 400), 8'h01);
    q = rspData;
    if (!rd) chk("wraddr", 8'(wrAddr), 8'(a));
    @(posedge sys_clk) #1;
    if (!rd) chk("store", 8'(regData[a]), 8'(d[4:0]));
  endtask
  task t_reset;
    for (int i = 0; i < 32; i++) begin
      chk("rst", 8'(regData[i]), 8'(srp_pkg::REG_RESET));
    end
    xfer(1, 5'h1F, 8'h00);
    chk("rd31", 8'(q), 8'h00);
    $display("test reset done");
  endtask
  task t_walk;
    for (int i = 0; i < 5; i++) xfer(0, 5'(1 << i), 8'(8'hE3 + 8'(i * 6)));
    for (int i = 0; i < 5; i++) begin
      xfer(1, 5'(1 << i), 8'h00);
      chk("walk", 8'(q), 8'((8'hE3 + 8'(i * 6)) & 8'h1F));
    end
    $display("test walk done");
  endtask
  task t_overwrite;
    xfer(0, 5'h15, 8'h0A);
    xfer(0, 5'h15, 8'hF5);
    xfer(1, 5'h15, 8'h00);
    chk("ovr", 8'(q), 8'h15);
    xfer(1, 5'h0A, 8'h00);
    chk("other", 8'(q), 8'h00);
    $display("test overwrite done");
  endtask
  initial begin
    {reqValid, reqRead, reqAddr, reqWdata} = '0;
    sys_rst = 1;
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 0;
    t_reset();
    t_walk();
    t_overwrite();
    complete_run();
  end
endmodule // serial_register_port_test
`default_nettype wire
